// ===== src/dma_csr.sv
// control and status slave of a scatter-gather dma controller
// assumes axi4-lite master on clk; engine signals are on clk too
`timescale 1ns/1ps
`default_nettype none

module dma_csr
  import dma_csr_pkg::*;
#(
  parameter bit COALESCE_EN = 1'b1  // interrupt coalescing built in
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // descriptor engine events as one-cycle pulses, busy level and next pointer
  input  wire logic        fault_event,
  input  wire logic        packet_end_event,
  input  wire logic        desc_done_event,
  input  wire logic        list_done_event,
  input  wire logic        engine_busy,
  input  wire logic        next_ptr_valid,
  input  wire logic [31:0] next_ptr,
  // controls to the descriptor engine
  output var  logic        run_enable,
  output var  logic        halt_on_fault,
  output var  logic        park_enable,
  output var  logic        soft_reset_trigger,
  output var  logic [31:0] desc_ptr,
  output var  logic        irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] pointer_reg;
  logic [31:0] pointer_next;
  logic        busy_reg;
  logic [CTL_COUNT_W-1:0] count_reg;
  logic [CTL_COUNT_W-1:0] count_next;
  logic        soft_reset_reg;
  logic        irq_reg;
  logic        irq_next;

  logic [7:0]  awaddr_reg;
  logic        aw_full_reg;
  logic        aw_full_next;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_full_reg;
  logic        w_full_next;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // ----------------------------------------------------------------
  // write channel handshakes and commit
  // ----------------------------------------------------------------
  wire         aw_take = s_axi_awvalid & awready_reg;
  wire         w_take  = s_axi_wvalid & wready_reg;
  wire         b_done  = bvalid_reg & s_axi_bready;
  // address and data may arrive in either order; commit once both held
  wire         commit  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire [7:0]   waddr   = {awaddr_reg[7:2], 2'b00};

  assign aw_full_next = commit ? 1'b0 : (aw_full_reg | aw_take);
  assign w_full_next  = commit ? 1'b0 : (w_full_reg | w_take);
  assign bvalid_next  = commit ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);

  // ----------------------------------------------------------------
  // write address decode
  // ----------------------------------------------------------------
  // word decode
  wire         wr_status  = commit & (waddr == STATUS_ADDR);
  wire         wr_control = commit & (waddr == CONTROL_ADDR);
  wire         wr_pointer = commit & (waddr == POINTER_ADDR);
  wire         wr_hit     = wr_status | wr_control | wr_pointer;
  wire [31:0]  lane_mask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0]  ctl_wmask  = lane_mask & CTL_STORE_MASK;

  wire         soft_hit   = wr_control & wstrb_reg[2] & wdata_reg[CTL_SOFT_RESET];
  wire         irq_clear  = wr_control & wstrb_reg[3] & wdata_reg[CTL_IRQ_CLEAR];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // halt on fault drops run
  wire         fault_halt = fault_event & control_reg[CTL_HALT_FAULT];

  // soft reset zeroes control; a fault with halt set also drops run
  always_comb
  begin
    control_next = control_reg;
    if (soft_hit)
      control_next = CTL_RESET;
    else if (wr_control)
      control_next = (control_reg & ~ctl_wmask) | (wdata_reg & ctl_wmask);
    if (fault_halt && !soft_hit)
      control_next[CTL_RUN] = 1'b0;
  end

  // ----------------------------------------------------------------
  // descriptor chain pointer
  // ----------------------------------------------------------------
  // hardware advance beats software write
  assign pointer_next = next_ptr_valid ? next_ptr :
                        wr_pointer ? ((pointer_reg & ~lane_mask) | (wdata_reg & lane_mask)) :
                        pointer_reg;

  // ----------------------------------------------------------------
  // sticky flags and coalescing
  // ----------------------------------------------------------------
  logic [PEND_COALESCE:0] flag_set;
  logic [PEND_COALESCE:0] flag_clr;
  logic [PEND_COALESCE:0] pending;

  wire         count_limit_set = control_reg[CTL_COUNT_LSB +: CTL_COUNT_W] != '0;
  wire         coalesce_on     = COALESCE_EN & control_reg[CTL_COALESCE_IE] & count_limit_set;
  wire [CTL_COUNT_W-1:0] count_inc = count_reg + 1'b1;
  wire         coalesce_hit = coalesce_on & desc_done_event &
                              (count_inc == control_reg[CTL_COUNT_LSB +: CTL_COUNT_W]);

  assign count_next = soft_hit ? '0 :
                      coalesce_hit ? '0 :
                      (coalesce_on & desc_done_event) ? count_inc : count_reg;

  assign flag_set = {coalesce_hit, list_done_event, desc_done_event,
                     packet_end_event, fault_event};

  // write one clears the status flags; irq clear clears every pending source
  assign flag_clr = {irq_clear,
                     {STS_FLAGS{irq_clear}} |
                     ({STS_FLAGS{wr_status & wstrb_reg[0]}} & wdata_reg[STS_FLAGS-1:0])};

  // one sticky cell per pending source
  genvar gi;
  generate
    for (gi = 0; gi <= PEND_COALESCE; gi++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clk         (clk),
        .nrst        (nrst),
        .set_pulse   (flag_set[gi]),
        .clear_pulse (flag_clr[gi]),
        .kill_pulse  (soft_hit),
        .flag        (pending[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // per-flag enables; master gate; level while pending
  wire [STS_FLAGS-1:0] flag_ie = control_reg[CTL_LIST_DONE_IE:CTL_FAULT_IE];
  wire         any_source = (|(pending[STS_FLAGS-1:0] & flag_ie)) |
                            (pending[PEND_COALESCE] & control_reg[CTL_COALESCE_IE]);
  assign irq_next = control_next[CTL_MASTER_IE] & any_source & ~irq_clear & ~soft_hit;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire         ar_take = s_axi_arvalid & arready_reg;
  wire         r_done  = rvalid_reg & s_axi_rready;
  wire [7:0]   raddr   = {s_axi_araddr[7:2], 2'b00};
  wire [31:0]  status_word = {27'h0, busy_reg, pending[STS_FLAGS-1:0]};

  // word decode for reads; pointer read is software's care
  wire         rd_status  = raddr == STATUS_ADDR;
  wire         rd_control = raddr == CONTROL_ADDR;
  wire         rd_pointer = raddr == POINTER_ADDR;
  wire [31:0]  rd_word    = rd_status  ? status_word :
                            rd_control ? control_reg :
                            rd_pointer ? pointer_reg : 32'h0000_0000;
  wire         rd_hit     = rd_status | rd_control | rd_pointer;

  assign rvalid_next = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);

  // ----------------------------------------------------------------
  // bus channel registers
  // ----------------------------------------------------------------
  // write address and data capture, ready low while held
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
    end
  end

  // payload capture and write response code
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bresp_reg  <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        awaddr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (commit)
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel, one word per request
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // block state registers
  // ----------------------------------------------------------------
  // everything zero after device reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control_reg    <= CTL_RESET;
      pointer_reg    <= POINTER_RESET;
      busy_reg       <= 1'b0;
      count_reg      <= '0;
      soft_reset_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end
    else
    begin
      control_reg    <= control_next;
      pointer_reg    <= pointer_next;
      busy_reg       <= engine_busy;
      count_reg      <= count_next;
      soft_reset_reg <= soft_hit;
      irq_reg        <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // run permits next descriptor; engine finishes current one
  assign run_enable         = control_reg[CTL_RUN];
  assign halt_on_fault      = control_reg[CTL_HALT_FAULT];
  assign park_enable        = control_reg[CTL_PARK];
  // one-cycle pulse halts engine at once
  assign soft_reset_trigger = soft_reset_reg;
  assign desc_ptr           = pointer_reg;
  assign irq                = irq_reg;

endmodule : dma_csr

`default_nettype wire

// ===== src/dma_csr_pkg.sv
// constants for the scatter-gather dma control and status slave
// assumes a 32-bit axi4-lite register bus and one clock domain
package dma_csr_pkg;

  // ----------------------------------------------------------------
  // register map: printed word indexes, byte address = 4 * index
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_INDEX  = 8'h00;
  localparam logic [7:0] CONTROL_INDEX = 8'h01;
  localparam logic [7:0] POINTER_INDEX = 8'h02;
  localparam logic [7:0] STATUS_ADDR   = 8'(STATUS_INDEX  * 4);
  localparam logic [7:0] CONTROL_ADDR  = 8'(CONTROL_INDEX * 4);
  localparam logic [7:0] POINTER_ADDR  = 8'(POINTER_INDEX * 4);

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_FAULT_IE    = 0;
  localparam int CTL_PKT_END_IE  = 1;
  localparam int CTL_DESC_DONE_IE = 2;
  localparam int CTL_LIST_DONE_IE = 3;
  localparam int CTL_MASTER_IE   = 4;
  localparam int CTL_RUN         = 5;
  localparam int CTL_HALT_FAULT  = 6;
  localparam int CTL_COALESCE_IE = 7;
  localparam int CTL_COUNT_LSB   = 8;
  localparam int CTL_COUNT_W     = 8;
  localparam int CTL_SOFT_RESET  = 16;
  localparam int CTL_PARK        = 17;
  localparam int CTL_IRQ_CLEAR   = 31;
  // bits that hold a value; 16 and 31 act on write and read as zero
  localparam logic [31:0] CTL_STORE_MASK = 32'h0002_ffff;
  localparam logic [31:0] CTL_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STS_FAULT     = 0;
  localparam int STS_PKT_END   = 1;
  localparam int STS_DESC_DONE = 2;
  localparam int STS_LIST_DONE = 3;
  localparam int STS_BUSY      = 4;
  localparam int STS_FLAGS     = 4;  // sticky flags in bits 3..0
  localparam int PEND_COALESCE = 4;  // fifth pending source, no status bit

  localparam logic [31:0] POINTER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // axi4-lite response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dma_csr_pkg

// ===== src/sticky_flag.sv
// one sticky event flag with set-over-clear priority
// assumes set, clear and kill are single-clock pulses on clk
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic set_pulse,   // hardware event
  input  wire logic clear_pulse, // software clear
  input  wire logic kill_pulse,  // soft reset, beats everything
  output var  logic flag
);

  logic flag_reg;
  logic flag_next;

  // kill first, then set wins over a clear in the same cycle
  assign flag_next = kill_pulse  ? 1'b0 :
                     set_pulse   ? 1'b1 :
                     clear_pulse ? 1'b0 : flag_reg;

  // flag storage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;

endmodule : sticky_flag

`default_nettype wire

// ===== tb/dma_csr_chk.sv
// assertions on the csr slave ports: bus timing, decode, engine controls
// assumes one clock domain, nrst asynchronous active low
`timescale 1ns/1ps
`default_nettype none

module dma_csr_chk
  import dma_csr_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        fault_event,
  input wire logic        engine_busy,
  input wire logic        next_ptr_valid,
  input wire logic [31:0] next_ptr,
  input wire logic        run_enable,
  input wire logic        halt_on_fault,
  input wire logic        park_enable,
  input wire logic        soft_reset_trigger,
  input wire logic [31:0] desc_ptr,
  input wire logic        irq
);
  logic [7:0] wr_addr_q;
  logic       wr_clear_q;
  logic [7:0] rd_addr_q;
  logic       wr_unmapped;

  // remember address and clear request of the accesses in flight
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_addr_q  <= 8'h00;
      wr_clear_q <= 1'b0;
      rd_addr_q  <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        wr_addr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wr_clear_q <= s_axi_wdata[CTL_IRQ_CLEAR] && s_axi_wstrb[3];
      if (s_axi_arvalid && s_axi_arready)
        rd_addr_q <= s_axi_araddr;
    end
  end

  // words beyond the pointer register are not decoded
  assign wr_unmapped = wr_addr_q[7:2] > POINTER_INDEX[5:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid && !s_axi_awready;
  endsequence

  a_write_answer_time: assert property (s_wr_take |=> s_wr_answer)
    else $error("write answer not two edges after take");
  a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one edge after take");
  a_write_decode_resp: assert property ($rose(s_axi_bvalid)
    |-> s_axi_bresp == (wr_unmapped ? RESP_SLVERR : RESP_OKAY))
    else $error("write response code wrong");
  a_control_reserved_zero: assert property ($rose(s_axi_rvalid) && rd_addr_q == CONTROL_ADDR
    |-> s_axi_rdata[31:18] == 14'h0 && !s_axi_rdata[CTL_SOFT_RESET])
    else $error("control reserved bits not zero");
  a_status_busy_follow: assert property ($rose(s_axi_rvalid) && rd_addr_q == STATUS_ADDR
    |-> s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[STS_BUSY] == $past(engine_busy, 2))
    else $error("status busy or upper bits wrong");
  a_fault_halts_run: assert property (fault_event && halt_on_fault |=> !run_enable)
    else $error("run kept after fault with halt");
  a_soft_reset_pulse: assert property (soft_reset_trigger
    |-> !run_enable && !halt_on_fault && !park_enable ##1 !soft_reset_trigger)
    else $error("soft reset pulse or control clear wrong");
  a_irq_clear_drop: assert property ($rose(s_axi_bvalid) && wr_clear_q
    && wr_addr_q == CONTROL_ADDR |-> !irq)
    else $error("irq not dropped by clear");
  a_ptr_follow_engine: assert property (next_ptr_valid |=> desc_ptr == $past(next_ptr))
    else $error("pointer not loaded from engine");
endmodule : dma_csr_chk

bind dma_csr dma_csr_chk i_chk
(
  .clk(clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .fault_event(fault_event), .engine_busy(engine_busy), .next_ptr_valid(next_ptr_valid),
  .next_ptr(next_ptr), .run_enable(run_enable), .halt_on_fault(halt_on_fault),
  .park_enable(park_enable), .soft_reset_trigger(soft_reset_trigger),
  .desc_ptr(desc_ptr), .irq(irq)
);
`default_nettype wire

// ===== tb/dma_csr_tb.sv
// self-checking bench for the dma csr slave over axi4-lite
// assumes the checker binds itself and the engine model drives events
`timescale 1ns/1ps
`default_nettype none

module dma_csr_tb
  import dma_csr_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, engine_busy, next_ptr_valid;
  logic        run_enable, halt_on_fault, park_enable, soft_reset_trigger;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ev;
  logic [31:0] rdata, desc_ptr, next_ptr, p;
  int          errors = 0;
  int          compares = 0;
  int          resets = 0;
  bit          ran;

  dma_csr #(.COALESCE_EN(1'b1)) i_dut
  (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_event(ev[0]), .packet_end_event(ev[1]), .desc_done_event(ev[2]),
    .list_done_event(ev[3]), .engine_busy(engine_busy), .next_ptr_valid(next_ptr_valid),
    .next_ptr(next_ptr), .run_enable(run_enable), .halt_on_fault(halt_on_fault),
    .park_enable(park_enable), .soft_reset_trigger(soft_reset_trigger),
    .desc_ptr(desc_ptr), .irq(irq)
  );

  dma_engine_model i_eng
  (
    .clk(clk), .run_enable(run_enable), .park_enable(park_enable),
    .soft_reset_trigger(soft_reset_trigger), .desc_ptr(desc_ptr), .events(ev),
    .engine_busy(engine_busy), .next_ptr_valid(next_ptr_valid), .next_ptr(next_ptr)
  );

  // 10 mhz clock and soft reset pulse counter
  always #50 clk = ~clk;
  always @(posedge clk)
    if (soft_reset_trigger === 1'b1)
      resets++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // one clock of a bounded wait
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 100)
    begin
      errors++;
      $display("[FAIL] %0t no bus answer", $time);
      complete_run();
    end
  endtask : tick

  // single-word write, address and data together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    bit done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      tick(n);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        done = 1'b1;
      end
    end
  endtask : wr

  // single-word read compared with the expected word and code
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    bit done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      tick(n);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        check(rdata, d);
        check({30'h0, rresp}, {30'h0, er});
        done = 1'b1;
      end
    end
  endtask : rd

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    rd(CONTROL_ADDR, 32'h0, RESP_OKAY);
    rd(POINTER_ADDR, 32'h0, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'hffff_ffff, RESP_SLVERR);
    wr(CONTROL_ADDR, 32'hfffe_ffcf, RESP_OKAY);
    rd(CONTROL_ADDR, 32'h0002_ffcf, RESP_OKAY);
    check({29'h0, park_enable, halt_on_fault, run_enable}, 32'h6);
    for (int i = 0; i < 4; i++)
    begin
      wr(CONTROL_ADDR, 32'h1 << i, RESP_OKAY);
      i_eng.pulse(4'h1 << i);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0);
      rd(STATUS_ADDR, 32'h1 << i, RESP_OKAY);
      wr(CONTROL_ADDR, 32'h10 | (32'h1 << i), RESP_OKAY);
      @(posedge clk);
      chk1(irq, 1'b1);
      wr(CONTROL_ADDR, 32'h8000_0010 | (32'h1 << i), RESP_OKAY);
      @(posedge clk);
      chk1(irq, 1'b0);
      rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    end
    i_eng.pulse(4'h5);
    wr(STATUS_ADDR, 32'h1, RESP_OKAY);
    rd(STATUS_ADDR, 32'h4, RESP_OKAY);
    wr(POINTER_ADDR, 32'h0000_0100, RESP_OKAY);
    check(desc_ptr, 32'h0000_0100);
    wr(CONTROL_ADDR, 32'h8000_0034, RESP_OKAY);
    fork
      i_eng.run_desc(4'h0, 12, ran);
      begin
        repeat (4) @(posedge clk);
        rd(STATUS_ADDR, 32'h10, RESP_OKAY);
      end
    join
    repeat (3) @(posedge clk);
    check(desc_ptr, 32'h0000_0120);
    rd(STATUS_ADDR, 32'h4, RESP_OKAY);
    chk1(irq, 1'b1);
    wr(CONTROL_ADDR, 32'h8000_0014, RESP_OKAY);
    i_eng.run_desc(4'h0, 1, ran);
    chk1(ran, 1'b0);
    wr(CONTROL_ADDR, 32'h0000_0020, RESP_OKAY);
    fork
      i_eng.run_desc(4'h0, 12, ran);
      begin
        repeat (2) @(posedge clk);
        wr(CONTROL_ADDR, 32'h0, RESP_OKAY);
        rd(STATUS_ADDR, 32'h10, RESP_OKAY);
      end
    join
    chk1(ran, 1'b1);
    wr(CONTROL_ADDR, 32'h0000_0060, RESP_OKAY);
    i_eng.run_desc(4'h1, 2, ran);
    @(posedge clk);
    chk1(run_enable, 1'b0);
    rd(STATUS_ADDR, 32'h5, RESP_OKAY);
    rd(CONTROL_ADDR, 32'h40, RESP_OKAY);
    wr(CONTROL_ADDR, 32'h8000_02b0, RESP_OKAY);
    i_eng.run_desc(4'h0, 1, ran);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
    i_eng.run_desc(4'h0, 1, ran);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1);
    p = desc_ptr;
    wr(CONTROL_ADDR, 32'h0003_0060, RESP_OKAY);
    repeat (2) @(posedge clk);
    check(resets, 32'h1);
    chk1(irq, 1'b0);
    rd(CONTROL_ADDR, 32'h0, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    rd(POINTER_ADDR, p, RESP_OKAY);
    complete_run();
  end
endmodule : dma_csr_tb
`default_nettype wire

// ===== tb/dma_engine_model.sv
// behavioural descriptor engine facing the csr slave
// assumes same-clock pulses; the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none

module dma_engine_model
(
  input  wire logic        clk,
  input  wire logic        run_enable,
  input  wire logic        park_enable,
  input  wire logic        soft_reset_trigger,
  input  wire logic [31:0] desc_ptr,
  output var  logic [3:0]  events,
  output var  logic        engine_busy,
  output var  logic        next_ptr_valid,
  output var  logic [31:0] next_ptr
);
  // idle outputs at time zero
  initial
  begin
    events = 4'h0;
    engine_busy = 1'b0;
    next_ptr_valid = 1'b0;
    next_ptr = 32'h0;
  end

  // one-cycle pulse on the chosen event lines
  task automatic pulse(input logic [3:0] ev);
    @(posedge clk);
    events <= ev;
    @(posedge clk);
    events <= 4'h0;
  endtask : pulse

  // one descriptor: start only while run is set, abort on soft reset
  task automatic run_desc(input logic [3:0] ev, input int cyc, output bit ran);
    ran = 1'b0;
    @(posedge clk);
    if (!run_enable)
      return;
    ran = 1'b1;
    engine_busy <= 1'b1;
    repeat (cyc)
    begin
      @(posedge clk);
      if (soft_reset_trigger)
      begin
        engine_busy <= 1'b0;
        return;
      end
    end
    events <= ev | 4'h4;
    next_ptr_valid <= 1'b1;
    // next aligned slot, or same slot when parked
    next_ptr <= park_enable ? desc_ptr : desc_ptr + 32'h20;
    @(posedge clk);
    events <= 4'h0;
    next_ptr_valid <= 1'b0;
    next_ptr <= ~next_ptr; // stale pointer is not held
    engine_busy <= 1'b0;
  endtask : run_desc
endmodule : dma_engine_model
`default_nettype wire
